// *** hw/slew_stepper.sv ***
/*
  Moves the applied code one step per slew interval toward the goal.
  Assumes rate_sel is stable; interval is 4 us shifted left by rate_sel.
*/
`timescale 1ns/1ps
`include "vout_regs_defines.svh"
module slew_stepper #(
  parameter int BASE_CYCLES = `SLEW_BASE_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic load,
  input  wire vout_pkg::code_t load_code,
  slew_if.step      sif
);

  // ----------------------------------------------------------------------
  // Interval timer
  // ----------------------------------------------------------------------
  logic [15:0]     tick_reg;
  vout_pkg::code_t level_reg;
  wire  [15:0]     interval = 16'(BASE_CYCLES) << sif.rate_sel;
  wire             tick_done = (tick_reg >= interval - 16'h0001);
  wire             at_goal = (level_reg == sif.goal);

  always_ff @(posedge clk) begin
    if (!rst_b || load || at_goal || tick_done) begin
      tick_reg <= 16'h0000;
    end else begin
      tick_reg <= tick_reg + 16'h0001;
    end
  end

  // One code per interval; only the power-up load jumps
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      level_reg <= 12'h000;
    end else if (load) begin
      level_reg <= load_code;
    end else if (tick_done && !at_goal) begin
      level_reg <= (level_reg < sif.goal) ? level_reg + 12'h001 : level_reg - 12'h001;
    end
  end

  assign sif.level   = level_reg;
  assign sif.settled = at_goal;

endmodule : slew_stepper

// *** hw/vout_status_bank.sv ***
/*
  Output voltage target and summary status register bank.
  Assumes a command decoder outside presents decoded register reads and
  writes, and that fault sources are synchronous level inputs.
*/
// Notes on behaviour
// - Voltage format register reads fixed 0x17: linear code, exponent minus nine.
// - Codes are unsigned mantissas times two to minus nine, about 1.95 mV each.
// - Codes are twelve-bit; only 307 to 614 is supported.
// - Output moves one code per slew interval of 4, 8, 16 or 32 us.
// - While output is on, margin high drives raised code; margin low drives lowered code.
// - Off flag set when commanded off or tri-stated by lockout faults.
// - Off flag clear while output is still driven, even under OV or OC.
// - Bit 5 flags an output overvoltage fault.
// - Bit 4 flags an output overcurrent fault.
// - Bit 3 flags an input undervoltage fault.
// - Bit 2 flags a temperature fault or warning.
// - Bit 1 flags a communication, memory or logic fault.
// - Bit 0 flags other faults; bit 7 is unused.
// - Margin select 00xx none, 0101/0110 low, 1001/1010 high.
// - Fault clear empties status bits 5 to 0 and releases alert.
// - A fault still present re-sets its flag at once and raises alert.
`timescale 1ns/1ps
`include "vout_regs_defines.svh"
module vout_status_bank #(
  parameter int SLEW_BASE_CYCLES = `SLEW_BASE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [11:0] strap_code,
  input  wire logic [1:0]  strap_slew,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] rd_data,
  output logic             rd_valid,
  output logic             cmd_unknown,
  input  wire logic        output_on,
  input  wire logic [3:0]  margin_select,
  input  wire logic        clear_faults,
  input  wire logic        ov_fault,
  input  wire logic        oc_fault,
  input  wire logic        bias_uv_fault,
  input  wire logic        undervoltage_fault,
  input  wire logic        overtemperature,
  input  wire logic        temp_warning,
  input  wire logic        bias_lockout,
  input  wire logic        cml_fault,
  input  wire logic        other_fault,
  output logic      [11:0] applied_code,
  output logic             code_settled,
  output logic             alert_b
);

  // ----------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------
  function automatic vout_pkg::margin_t margin_decode(input logic [3:0] sel);
    if (sel == 4'h5 || sel == 4'h6) begin
      return vout_pkg::MARGIN_LOW;
    end else if (sel == 4'h9 || sel == 4'hA) begin
      return vout_pkg::MARGIN_HIGH;
    end else begin
      return vout_pkg::MARGIN_NONE;
    end
  endfunction : margin_decode

  // Used for both the live goal and the power-up load, so the stepper never starts outside range
  function automatic vout_pkg::code_t clamp_code(input vout_pkg::code_t code);
    if (code < `CODE_MIN) begin
      return `CODE_MIN;
    end else if (code > `CODE_MAX) begin
      return `CODE_MAX;
    end else begin
      return code;
    end
  endfunction : clamp_code

  wire hit_target  = (cmd_code == `CMD_TARGET_CODE);
  wire hit_raised  = (cmd_code == `CMD_RAISED_CODE);
  wire hit_lowered = (cmd_code == `CMD_LOWERED_CODE);
  wire hit_format  = (cmd_code == `CMD_VOLTAGE_FORMAT);
  wire hit_flags   = (cmd_code == `CMD_SUMMARY_FLAGS);
  wire hit_any     = hit_target | hit_raised | hit_lowered | hit_format | hit_flags;
  wire [11:0] wr_code = 12'(wr_data & `CODE_WR_MASK);

  // ----------------------------------------------------------------------
  // Voltage code registers
  // ----------------------------------------------------------------------
  vout_pkg::code_t target_reg;
  vout_pkg::code_t raised_reg;
  vout_pkg::code_t lowered_reg;
  logic            loaded_reg;

  // Reset loads a constant; the strap is taken on the first edge after release
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      target_reg <= 12'h000;
    end else if (!loaded_reg) begin
      target_reg <= strap_code;
    end else if (wr_en && hit_target) begin
      target_reg <= wr_code;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      raised_reg <= 12'h000;
    end else if (!loaded_reg) begin
      raised_reg <= strap_code;
    end else if (wr_en && hit_raised) begin
      raised_reg <= wr_code;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lowered_reg <= 12'h000;
    end else if (!loaded_reg) begin
      lowered_reg <= strap_code;
    end else if (wr_en && hit_lowered) begin
      lowered_reg <= wr_code;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      loaded_reg <= 1'b0;
    end else begin
      loaded_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Goal selection and slewing
  // ----------------------------------------------------------------------
  vout_pkg::margin_t margin_mode;
  vout_pkg::code_t   raw_goal;
  vout_pkg::code_t   clamped_goal;
  assign margin_mode = margin_decode(margin_select);
  assign raw_goal = (output_on && margin_mode == vout_pkg::MARGIN_HIGH) ? raised_reg :
                    (output_on && margin_mode == vout_pkg::MARGIN_LOW)  ? lowered_reg :
                    target_reg;
  // Out-of-range codes are held at the nearest supported limit
  assign clamped_goal = clamp_code(raw_goal);
  // Code registers still hold reset zero on the load edge, so load from the strap itself
  vout_pkg::code_t   strap_goal;
  assign strap_goal = clamp_code(strap_code);

  slew_if sif ();
  assign sif.goal     = clamped_goal;
  assign sif.rate_sel = strap_slew;

  slew_stepper #(
    .BASE_CYCLES (SLEW_BASE_CYCLES)
  ) u_step (
    .clk       (clk),
    .rst_b     (rst_b),
    .load      (!loaded_reg),
    .load_code (strap_goal),
    .sif       (sif)
  );

  assign applied_code = sif.level;
  assign code_settled = sif.settled;

  // ----------------------------------------------------------------------
  // Summary flags
  // ----------------------------------------------------------------------
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] fault_now;
  logic       off_now;
  logic       alert_reg;

  // Lockout faults tri-state the stage; OV and OC keep it switching
  assign off_now = !output_on || undervoltage_fault || overtemperature
                   || bias_lockout;

  always_comb begin
    fault_now                  = 8'h00;
    fault_now[`FLAG_OFF_BIT]   = off_now;
    fault_now[`FLAG_OV_BIT]    = ov_fault;
    fault_now[`FLAG_OC_BIT]    = oc_fault;
    fault_now[`FLAG_UV_BIT]    = bias_uv_fault;
    fault_now[`FLAG_TEMP_BIT]  = overtemperature | temp_warning;
    fault_now[`FLAG_CML_BIT]   = cml_fault | cmd_unknown;
    fault_now[`FLAG_OTHER_BIT] = other_fault | undervoltage_fault;
  end

  // Present faults win over a clear, so nothing is lost in that cycle
  always_comb begin
    flags_next = clear_faults ? fault_now : (flags_reg | fault_now);
    flags_next[`FLAG_OFF_BIT] = off_now;
    flags_next[7] = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flags_reg <= 8'h00;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Off alone is a state, not an event, so it does not raise alert
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      alert_reg <= 1'b0;
    end else begin
      alert_reg <= |flags_next[5:0];
    end
  end
  assign alert_b = !alert_reg;

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  wire [15:0] rd_mux = hit_format  ? {8'h00, `VOLTAGE_FORMAT_VAL} :
                       hit_target  ? {4'h0, target_reg}  :
                       hit_raised  ? {4'h0, raised_reg}  :
                       hit_lowered ? {4'h0, lowered_reg} :
                       hit_flags   ? {8'h00, flags_reg}  : 16'h0000;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_data     <= 16'h0000;
      rd_valid    <= 1'b0;
      cmd_unknown <= 1'b0;
    end else begin
      rd_data     <= rd_en ? rd_mux : rd_data;
      rd_valid    <= rd_en;
      cmd_unknown <= (rd_en || wr_en) && !hit_any;
    end
  end

endmodule : vout_status_bank

// *** inc/slew_if.sv ***
/*
  Carrier between the register bank and the slew stepper.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface slew_if;
  vout_pkg::code_t goal;
  vout_pkg::code_t level;
  logic            settled;
  logic [1:0]      rate_sel;

  modport bank (output goal, output rate_sel, input level, input settled);
  modport step (input goal, input rate_sel, output level, output settled);
endinterface : slew_if

// *** inc/vout_pkg.sv ***
/*
  Types shared by the register bank and its slew stepper.
  Assumes nothing beyond the defines header.
*/
package vout_pkg;

  typedef logic [11:0] code_t;

  typedef enum logic [1:0] {
    MARGIN_NONE,
    MARGIN_LOW,
    MARGIN_HIGH
  } margin_t;

endpackage : vout_pkg

// *** inc/vout_regs_defines.svh ***
/*
  Offsets, field positions, reset values and timing counts for the output
  voltage and summary status register bank. Assumes a 100 MHz logic clock.
*/
`ifndef VOUT_REGS_DEFINES_SVH
`define VOUT_REGS_DEFINES_SVH

// ----------------------------------------------------------------------
// Register command codes
// ----------------------------------------------------------------------
`define CMD_VOLTAGE_FORMAT   8'h20
`define CMD_TARGET_CODE      8'h21
`define CMD_RAISED_CODE      8'h25
`define CMD_LOWERED_CODE     8'h26
`define CMD_SUMMARY_FLAGS    8'h78

// ----------------------------------------------------------------------
// Field layouts and reset values
// ----------------------------------------------------------------------
`define VOLTAGE_FORMAT_VAL   8'h17
`define CODE_WR_MASK         16'h0FFF
`define CODE_MIN             12'h133
`define CODE_MAX             12'h266
`define FLAG_OFF_BIT         6
`define FLAG_OV_BIT          5
`define FLAG_OC_BIT          4
`define FLAG_UV_BIT          3
`define FLAG_TEMP_BIT        2
`define FLAG_CML_BIT         1
`define FLAG_OTHER_BIT       0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_MHZ              100
`define SLEW_BASE_US         4
`define SLEW_BASE_CYCLES     (`SLEW_BASE_US * `CLK_MHZ)

`endif

// *** verif/tb_vout_status_bank.sv ***
/* Self-checking bench for vout_status_bank driven through the host model.
   Assumes the slew base count is cut to 4 cycles. */
`timescale 1ns/1ps
`include "vout_regs_defines.svh"
module tb_vout_status_bank;
  logic        clk           = 1'b0;
  logic        rst_b         = 1'b0;
  logic [11:0] strap_code    = 12'h150;
  logic [1:0]  strap_slew    = 2'h1;
  logic        output_on     = 1'b1;
  logic [3:0]  margin_select = 4'h0;
  logic        clear_faults  = 1'b0;
  logic [8:0]  flt           = 9'h000;
  wire         wr_en, rd_en, rd_valid, cmd_unknown, code_settled, alert_b;
  wire  [7:0]  cmd_code;
  wire  [15:0] wr_data, rd_data;
  wire  [11:0] applied_code;
  logic [15:0] v, cnt;
  bit          ok;
  int          n_fail = 0, n_tests = 0, i;
  logic [3:0]  sel [6] = '{4'h5, 4'h9, 4'h6, 4'hA, 4'h3, 4'h0};
  logic [11:0] gl [6]  = '{12'h135, 12'h140, 12'h135, 12'h140, 12'h133, 12'h133};
  logic [15:0] fx [9]  = '{16'h0020, 16'h0010, 16'h0008, 16'h0041, 16'h0044,
                           16'h0004, 16'h0040, 16'h0002, 16'h0001};
  always #5 clk = ~clk;
  vout_status_bank #(.SLEW_BASE_CYCLES(4)) DUT (.clk, .rst_b, .strap_code, .strap_slew, .wr_en,
    .rd_en, .cmd_code, .wr_data, .rd_data, .rd_valid, .cmd_unknown, .output_on, .margin_select,
    .clear_faults, .ov_fault(flt[0]), .oc_fault(flt[1]), .bias_uv_fault(flt[2]),
    .undervoltage_fault(flt[3]), .overtemperature(flt[4]), .temp_warning(flt[5]),
    .bias_lockout(flt[6]), .cml_fault(flt[7]), .other_fault(flt[8]), .applied_code,
    .code_settled, .alert_b);
  vout_host_model host (.clk, .rd_data, .rd_valid, .wr_en, .rd_en, .cmd_code, .wr_data);
  // --------
  // Tasks
  // --------
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic stop_if(input bit hung);
    if (hung) begin
      n_fail++;
      give_verdict();
    end
  endtask : stop_if
  task automatic rd_chk(input logic [7:0] c, input logic [15:0] e, input string nm);
    host.rd(c, v, ok);
    stop_if(!ok);
    check(nm, v, e);
  endtask : rd_chk
  task automatic wait_code(input logic [11:0] e, input string nm);
    for (i = 0; i < 600 && !(code_settled === 1'b1 && applied_code === e); i++) @(negedge clk);
    stop_if(i == 600);
    check(nm, {4'h0, applied_code}, {4'h0, e});
  endtask : wait_code
  // Counts cycles to the next step, so two calls give one full interval
  task automatic step_gap();
    v = {4'h0, applied_code};
    for (cnt = 0; cnt < 100 && v === {4'h0, applied_code}; cnt++) @(negedge clk);
    stop_if(cnt == 100);
  endtask : step_gap
  task automatic pulse_clear();
    @(negedge clk);
    clear_faults = 1'b1;
    @(negedge clk);
    clear_faults = 1'b0;
  endtask : pulse_clear
  // --------
  // Sequence
  // --------
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    check("applied strap", {4'h0, applied_code}, 16'h0150);
    rd_chk(`CMD_VOLTAGE_FORMAT, 16'h0017, "format");
    rd_chk(`CMD_TARGET_CODE, 16'h0150, "target strap");
    rd_chk(`CMD_RAISED_CODE, 16'h0150, "raised strap");
    rd_chk(`CMD_LOWERED_CODE, 16'h0150, "lowered strap");
    host.wr(`CMD_VOLTAGE_FORMAT, 16'h00FF);
    rd_chk(`CMD_VOLTAGE_FORMAT, 16'h0017, "format read only");
    host.wr(`CMD_TARGET_CODE, 16'hF152);
    rd_chk(`CMD_TARGET_CODE, 16'h0152, "target top bits");
    step_gap();
    step_gap();
    check("slew interval", cnt, 16'h0008);
    wait_code(12'h152, "target reached");
    host.wr(`CMD_TARGET_CODE, 16'h0100);
    wait_code(12'h133, "clamped low");
    $display("Test codes and slewing done");
    host.wr(`CMD_RAISED_CODE, 16'h0140);
    host.wr(`CMD_LOWERED_CODE, 16'h0135);
    for (int k = 0; k < 6; k++) begin
      margin_select = sel[k];
      wait_code(gl[k], "margin goal");
    end
    $display("Test margins done");
    pulse_clear();
    host.wr(`CMD_SUMMARY_FLAGS, 16'h00FF);
    rd_chk(`CMD_SUMMARY_FLAGS, 16'h0000, "flags idle");
    for (int k = 0; k < 9; k++) begin
      flt = 9'h001 << k;
      repeat (2) @(negedge clk);
      rd_chk(`CMD_SUMMARY_FLAGS, fx[k], "flag map");
      check("alert", {15'h0000, alert_b}, {15'h0000, fx[k][5:0] == 6'h00});
      flt = 9'h000;
      pulse_clear();
      rd_chk(`CMD_SUMMARY_FLAGS, 16'h0000, "flags cleared");
      check("alert released", {15'h0000, alert_b}, 16'h0001);
    end
    flt = 9'h001;
    pulse_clear();
    rd_chk(`CMD_SUMMARY_FLAGS, 16'h0020, "fault still present");
    flt = 9'h000;
    pulse_clear();
    output_on = 1'b0;
    rd_chk(`CMD_SUMMARY_FLAGS, 16'h0040, "commanded off");
    output_on = 1'b1;
    rd_chk(8'h30, 16'h0000, "unmapped read");
    rd_chk(`CMD_SUMMARY_FLAGS, 16'h0002, "unknown command flag");
    $display("Test status flags done");
    give_verdict();
  end
endmodule : tb_vout_status_bank

// *** verif/vout_host_model.sv ***
/* Register host: one-strobe reads and writes on the decoded port.
   Assumes the bench calls its tasks one at a time. */
`timescale 1ns/1ps
module vout_host_model (
  input  wire logic        clk,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid,
  output logic             wr_en,
  output logic             rd_en,
  output logic      [7:0]  cmd_code,
  output logic      [15:0] wr_data
);
  // --------
  // Bus tasks
  // --------
  initial begin
    wr_en    = 1'b0;
    rd_en    = 1'b0;
    cmd_code = 8'h00;
    wr_data  = 16'h0000;
  end
  // Released lines show the inverse so a stale value never looks valid
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge clk);
    cmd_code = c;
    wr_data  = d;
    wr_en    = 1'b1;
    @(negedge clk);
    wr_en    = 1'b0;
    cmd_code = ~c;
    wr_data  = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] c, output logic [15:0] d, output bit ok);
    int i;
    @(negedge clk);
    cmd_code = c;
    rd_en    = 1'b1;
    @(negedge clk);
    rd_en    = 1'b0;
    cmd_code = ~c;
    ok       = 1'b0;
    d        = 16'hXXXX;
    for (i = 0; i < 4 && !ok; i++) begin
      if (rd_valid === 1'b1) begin
        ok = 1'b1;
        d  = rd_data;
      end else @(negedge clk);
    end
  endtask : rd
endmodule : vout_host_model

// *** verif/vout_status_bank_assertions.sv ***
/* Checker for the voltage code and summary flag bank.
   Assumes it is bound to vout_status_bank and sees only its ports. */
`timescale 1ns/1ps
`include "vout_regs_defines.svh"
module vout_status_bank_assertions #(
  parameter int SLEW_BASE_CYCLES = `SLEW_BASE_CYCLES
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [7:0]  cmd_code,
  input wire logic [15:0] rd_data,
  input wire logic        rd_valid,
  input wire logic        cmd_unknown,
  input wire logic        output_on,
  input wire logic        clear_faults,
  input wire logic        ov_fault,
  input wire logic        oc_fault,
  input wire logic        bias_uv_fault,
  input wire logic        undervoltage_fault,
  input wire logic        overtemperature,
  input wire logic        temp_warning,
  input wire logic        bias_lockout,
  input wire logic        cml_fault,
  input wire logic        other_fault,
  input wire logic [11:0] applied_code,
  input wire logic        alert_b
);
  // --------
  // Properties
  // --------
  wire is_code = cmd_code inside {`CMD_TARGET_CODE, `CMD_RAISED_CODE, `CMD_LOWERED_CODE};
  wire mapped  = is_code || cmd_code inside {`CMD_VOLTAGE_FORMAT, `CMD_SUMMARY_FLAGS};
  wire any_f   = ov_fault | oc_fault | bias_uv_fault | undervoltage_fault | overtemperature
               | temp_warning | bias_lockout | cml_fault | other_fault;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_flag_rd;
    rd_en && cmd_code == `CMD_SUMMARY_FLAGS;
  endsequence
  sequence s_alert_low;
    ##[1:2] !alert_b;
  endsequence
  a_format_value: assert property (rd_en && cmd_code == `CMD_VOLTAGE_FORMAT |=> rd_valid && rd_data == 16'h0017)
    else $error("format register read wrong");
  a_code_top_zero: assert property (rd_en && is_code |=> rd_data[15:12] == 4'h0)
    else $error("code register top bits not zero");
  a_off_flag: assert property (s_flag_rd ##0 (!output_on && !$past(output_on)) |=> rd_data[6])
    else $error("off flag clear while commanded off");
  a_unknown_cmd: assert property ((rd_en || wr_en) && !mapped |=> cmd_unknown)
    else $error("unmapped command not flagged");
  a_ov_alert: assert property (ov_fault |-> s_alert_low)
    else $error("overvoltage did not raise alert");
  a_alert_release: assert property (clear_faults && !any_f && !cmd_unknown |=> alert_b)
    else $error("alert not released by fault clear");
  a_slew_step: assert property ($changed(applied_code) && $past(rst_b, 2) |-> applied_code == $past(applied_code) + 12'h001 || applied_code == $past(applied_code) - 12'h001)
    else $error("applied code moved more than one step");
  a_code_range: assert property ($past(rst_b) |-> applied_code >= `CODE_MIN && applied_code <= `CODE_MAX)
    else $error("applied code outside supported range");
endmodule : vout_status_bank_assertions

bind vout_status_bank vout_status_bank_assertions #(.SLEW_BASE_CYCLES(SLEW_BASE_CYCLES)) chk (
  .clk, .rst_b, .wr_en, .rd_en, .cmd_code, .rd_data, .rd_valid, .cmd_unknown, .output_on,
  .clear_faults, .ov_fault, .oc_fault, .bias_uv_fault, .undervoltage_fault, .overtemperature,
  .temp_warning, .bias_lockout, .cml_fault, .other_fault, .applied_code, .alert_b);
